// *** core/vrf_pkg.sv ***
// Package holding constants, register map and types of the video row fetch controller.
package vrf_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int LINE_PERIOD_NS = 44444;
  localparam int LINE_CYCLES = LINE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CHAR_DIV = 2;
  localparam int H_TOTAL = LINE_CYCLES / CHAR_DIV;
  localparam int ROWS = 27;
  localparam int LINES_PER_ROW = 13;
  localparam int VRETRACE_LINES = 24;
  localparam int V_ACTIVE = ROWS * LINES_PER_ROW;
  localparam int V_TOTAL = V_ACTIVE + VRETRACE_LINES;
  localparam int COLS_NARROW = 80;
  localparam int COLS_WIDE = 132;
  localparam logic [3:0] CELL_DOTS_NARROW = 4'h9;
  localparam logic [3:0] CELL_DOTS_WIDE = 4'h7;

  // ==========================================================================
  // Slots inside the horizontal and vertical blanking, counted from the end of active text
  localparam int HSYNC_START_OFS = 8;
  localparam int HSYNC_LEN = 16;
  localparam int SL_SLOT_OFS = 70;
  localparam int SL_BITS = 4;
  localparam int DW_SLOT_OFS = 80;
  localparam int VSYNC_START_OFS = 4;
  localparam int VSYNC_LEN = 3;

  // ==========================================================================
  // Register map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TBL_LO = 4'h1;
  localparam logic [3:0] REG_TBL_HI = 4'h2;
  localparam logic [3:0] REG_CUR_COL = 4'h3;
  localparam logic [3:0] REG_CUR_ROW = 4'h4;
  localparam logic [3:0] REG_SCR_START = 4'h5;
  localparam logic [3:0] REG_SCR_STOP = 4'h6;
  localparam logic [3:0] REG_SCR_OFS = 4'h7;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_ROW_NUM = 4'h9;
  localparam int CTRL_WIDE_BIT = 0;
  localparam int CTRL_EN_BIT = 1;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ==========================================================================
  // Row kinds held in the top two bits of the second table byte
  localparam logic [1:0] ROW_NORMAL = 2'h0;
  localparam logic [1:0] ROW_DWIDE = 2'h1;
  localparam logic [1:0] ROW_DHIGH = 2'h2;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } vrf_bus_req_type;

  typedef struct packed {
    logic [1:0] kind;
    logic [13:0] start;
  } vrf_row_entry_type;

  typedef enum logic [2:0] {
    FS_IDLE = 3'h0,
    FS_REQ = 3'h1,
    FS_TBL0 = 3'h3,
    FS_TBL1 = 3'h2,
    FS_WAIT = 3'h6,
    FS_BURST = 3'h7
  } vrf_fetch_state_type;

endpackage

// *** core/vrf_row_fetch.sv ***
// Video timing generator with row-table read and row burst fetch.
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps
module vrf_row_fetch #(
  parameter int CHAR_DIV = vrf_pkg::CHAR_DIV
) (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Register port.
  input wire vrf_pkg::vrf_bus_req_type i_reg_req,
  output logic [7:0] o_reg_rdata,
  // System bus side.
  output logic o_row_boundary_request_n,
  input wire logic i_video_bus_grant,
  input wire logic i_address_drive_control,
  output logic [15:0] o_sys_addr,
  output logic o_sys_addr_oe,
  input wire logic [7:0] i_sys_data,
  input wire logic [15:0] i_dram_word,
  // Row buffer static RAM.
  output logic [7:0] o_rowbuf_addr,
  output logic o_rowbuf_we,
  output logic [7:0] o_rowbuf_char,
  output logic [7:0] o_rowbuf_attr,
  input wire logic [7:0] i_rowbuf_char,
  input wire logic [7:0] i_rowbuf_attr,
  // Attribute and shifter stage.
  output logic o_char_load,
  output logic [7:0] o_video_char,
  output logic [7:0] o_video_attr,
  output logic [3:0] o_cell_width,
  output logic o_hsync,
  output logic o_vsync,
  output logic o_blank,
  output logic o_visible_line_time,
  output logic o_cursor,
  output logic o_scanline_gate_n,
  output logic o_scanline_serial_data
);

  localparam int HT = vrf_pkg::LINE_CYCLES / CHAR_DIV;

  // Refuse a divider that leaves too little blanking for the slots.
  if (CHAR_DIV < 1 || HT < vrf_pkg::COLS_WIDE + vrf_pkg::DW_SLOT_OFS + 4) begin : g_chk
    $error("CHAR_DIV leaves no room for blanking slots");
  end

  // ==========================================================================
  // Declarations
  logic [7:0] div_reg;
  logic char_en_reg;
  logic [7:0] hcount_reg;
  logic [8:0] vcount_reg;
  logic [4:0] row_reg;
  logic [3:0] line_reg;
  logic [7:0] ctrl_reg, tbl_lo_reg, tbl_hi_reg, cur_col_reg, cur_row_reg;
  logic [7:0] scr_start_reg, scr_stop_reg, scr_ofs_reg;
  vrf_pkg::vrf_fetch_state_type state_reg;
  vrf_pkg::vrf_row_entry_type entry_reg;
  logic [1:0] kind_reg;
  logic [7:0] bcnt_reg;
  logic [7:0] act_len;
  logic line_end, frame_end, row_last, new_row;
  logic [8:0] nx_vcount;
  logic [3:0] nx_line;
  logic [4:0] nx_row;
  logic [1:0] nx_kind;
  logic [3:0] nx_scan;
  logic fetching;
  logic [7:0] hb;

  // Scan number seen by the shifter for a given line of a given row.
  function automatic logic [3:0] scan_of(input logic [3:0] line, input logic [4:0] row,
                                         input logic [1:0] kind);
    logic [4:0] s;
    s = {1'b0, line};
    if ({3'h0, row} >= scr_start_reg && {3'h0, row} <= scr_stop_reg) begin
      s = s + {1'b0, scr_ofs_reg[3:0]};
      if (s >= 5'(vrf_pkg::LINES_PER_ROW)) begin
        s = s - 5'(vrf_pkg::LINES_PER_ROW);
      end
    end
    if (kind == vrf_pkg::ROW_DHIGH) begin
      s = s >> 1;
    end
    return s[3:0];
  endfunction

  // ==========================================================================
  // Character clock divider
  // One-cycle character enable every CHAR_DIV clocks.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_reg <= 8'h00;
      char_en_reg <= 1'b0;
    end else begin
      char_en_reg <= (div_reg == 8'(CHAR_DIV - 1));
      div_reg <= (div_reg == 8'(CHAR_DIV - 1)) ? 8'h00 : div_reg + 8'h01;
    end
  end

  // Active length and next-line decode.
  assign act_len = ctrl_reg[vrf_pkg::CTRL_WIDE_BIT] ? 8'(vrf_pkg::COLS_WIDE) :
                   8'(vrf_pkg::COLS_NARROW);
  assign hb = hcount_reg - act_len;
  assign line_end = char_en_reg && hcount_reg == 8'(HT - 1);
  assign frame_end = vcount_reg == 9'(vrf_pkg::V_TOTAL - 1);
  assign row_last = line_reg == 4'(vrf_pkg::LINES_PER_ROW - 1);
  assign nx_vcount = frame_end ? 9'h000 : vcount_reg + 9'h001;
  assign nx_line = (frame_end || vcount_reg >= 9'(vrf_pkg::V_ACTIVE - 1) || row_last) ?
                   4'h0 : line_reg + 4'h1;
  assign nx_row = frame_end ? 5'h00 :
                  (row_last && row_reg < 5'(vrf_pkg::ROWS - 1)) ? row_reg + 5'h01 : row_reg;
  assign new_row = nx_vcount < 9'(vrf_pkg::V_ACTIVE) && nx_line == 4'h0;
  assign nx_kind = new_row ? entry_reg.kind : kind_reg;
  assign nx_scan = scan_of(nx_line, nx_row, nx_kind);
  assign fetching = state_reg != vrf_pkg::FS_IDLE;

  // ==========================================================================
  // Raster counters
  // Character, line, row and line-in-row counters.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hcount_reg <= 8'h00;
      vcount_reg <= 9'h000;
      row_reg <= 5'h00;
      line_reg <= 4'h0;
      kind_reg <= vrf_pkg::ROW_NORMAL;
    end else if (char_en_reg) begin
      hcount_reg <= line_end ? 8'h00 : hcount_reg + 8'h01;
      if (line_end) begin
        vcount_reg <= nx_vcount;
        line_reg <= nx_line;
        row_reg <= nx_row;
        kind_reg <= nx_kind;
      end
    end
  end

  // ==========================================================================
  // Monitor timing outputs
  // Sync, blanking and cell width, all from flip-flops.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_hsync <= 1'b0;
      o_vsync <= 1'b0;
      o_blank <= 1'b1;
      o_visible_line_time <= 1'b0;
      o_cell_width <= vrf_pkg::CELL_DOTS_NARROW;
    end else begin
      o_hsync <= hcount_reg >= act_len + 8'(vrf_pkg::HSYNC_START_OFS) &&
                 hcount_reg < act_len + 8'(vrf_pkg::HSYNC_START_OFS + vrf_pkg::HSYNC_LEN);
      o_vsync <= vcount_reg >= 9'(vrf_pkg::V_ACTIVE + vrf_pkg::VSYNC_START_OFS) &&
                 vcount_reg < 9'(vrf_pkg::V_ACTIVE + vrf_pkg::VSYNC_START_OFS +
                                 vrf_pkg::VSYNC_LEN);
      o_blank <= hcount_reg >= act_len || vcount_reg >= 9'(vrf_pkg::V_ACTIVE);
      o_visible_line_time <= vcount_reg < 9'(vrf_pkg::V_ACTIVE);
      o_cell_width <= ctrl_reg[vrf_pkg::CTRL_WIDE_BIT] ? vrf_pkg::CELL_DOTS_WIDE :
                      vrf_pkg::CELL_DOTS_NARROW;
    end
  end

  // ==========================================================================
  // Scan line serial report and cursor
  // Next scan number goes out MSB first while the gate is low.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_scanline_gate_n <= 1'b1;
      o_scanline_serial_data <= 1'b0;
      o_cursor <= 1'b0;
    end else if (char_en_reg) begin
      if (hcount_reg >= act_len && hb >= 8'(vrf_pkg::SL_SLOT_OFS) &&
          hb < 8'(vrf_pkg::SL_SLOT_OFS + vrf_pkg::SL_BITS)) begin
        o_scanline_gate_n <= 1'b0;
        o_scanline_serial_data <= nx_scan[2'(vrf_pkg::SL_BITS - 1) -
                                          2'(hb - 8'(vrf_pkg::SL_SLOT_OFS))];
      end else begin
        o_scanline_gate_n <= 1'b1;
        o_scanline_serial_data <= 1'b0;
      end
      if (hcount_reg >= act_len) begin
        o_cursor <= hb == 8'(vrf_pkg::DW_SLOT_OFS) && nx_kind != vrf_pkg::ROW_NORMAL &&
                    nx_vcount < 9'(vrf_pkg::V_ACTIVE);
      end else begin
        o_cursor <= vcount_reg < 9'(vrf_pkg::V_ACTIVE) && {3'h0, row_reg} == cur_row_reg &&
                    hcount_reg == cur_col_reg;
      end
    end
  end

  // ==========================================================================
  // Row fetch state machine
  // Request, two table bytes, wait for the line start, then the burst.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= vrf_pkg::FS_IDLE;
      entry_reg <= '0;
      bcnt_reg <= 8'h00;
      o_sys_addr <= 16'h0000;
    end else if (char_en_reg) begin
      case (state_reg)
        vrf_pkg::FS_IDLE: begin
          // Only the line before a row's scan line zero fetches.
          if (ctrl_reg[vrf_pkg::CTRL_EN_BIT] && hcount_reg == act_len && new_row &&
              (row_last || frame_end)) begin
            state_reg <= vrf_pkg::FS_REQ;
          end
        end
        vrf_pkg::FS_REQ: begin
          if (i_video_bus_grant) begin
            state_reg <= vrf_pkg::FS_TBL0;
            o_sys_addr <= {tbl_hi_reg, tbl_lo_reg} + {10'h000, nx_row, 1'b0};
          end
        end
        vrf_pkg::FS_TBL0: begin
          entry_reg.start[7:0] <= i_sys_data;
          o_sys_addr <= o_sys_addr + 16'h0001;
          state_reg <= vrf_pkg::FS_TBL1;
        end
        vrf_pkg::FS_TBL1: begin
          entry_reg.start[13:8] <= i_sys_data[5:0];
          entry_reg.kind <= i_sys_data[7:6];
          state_reg <= vrf_pkg::FS_WAIT;
        end
        vrf_pkg::FS_WAIT: begin
          bcnt_reg <= 8'h00;
          if (line_end) begin
            state_reg <= vrf_pkg::FS_BURST;
            o_sys_addr <= {2'h0, entry_reg.start};
            bcnt_reg <= 8'h01;
          end
        end
        vrf_pkg::FS_BURST: begin
          // Address latched now is served on the next character time.
          if (bcnt_reg == act_len) begin
            state_reg <= vrf_pkg::FS_IDLE;
          end else begin
            o_sys_addr <= {2'h0, entry_reg.start} + {8'h00, bcnt_reg};
            bcnt_reg <= bcnt_reg + 8'h01;
          end
        end
        default: begin
          state_reg <= vrf_pkg::FS_IDLE;
        end
      endcase
    end
  end

  // Request and address drive; the data bus has no output at all.
  assign o_row_boundary_request_n = !fetching;
  assign o_sys_addr_oe = i_address_drive_control && state_reg != vrf_pkg::FS_IDLE &&
                         state_reg != vrf_pkg::FS_REQ;

  // ==========================================================================
  // Row buffer and video data
  // Burst words feed the display and split into the two row buffers.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rowbuf_we <= 1'b0;
      o_rowbuf_addr <= 8'h00;
      o_rowbuf_char <= 8'h00;
      o_rowbuf_attr <= 8'h00;
      o_video_char <= 8'h00;
      o_video_attr <= 8'h00;
      o_char_load <= 1'b0;
    end else begin
      o_char_load <= char_en_reg;
      o_rowbuf_we <= char_en_reg && state_reg == vrf_pkg::FS_BURST;
      if (char_en_reg && state_reg == vrf_pkg::FS_BURST) begin
        o_rowbuf_addr <= bcnt_reg - 8'h01;
        o_rowbuf_char <= i_dram_word[7:0];
        o_rowbuf_attr <= i_dram_word[15:8];
        o_video_char <= i_dram_word[7:0];
        o_video_attr <= i_dram_word[15:8];
      end else if (char_en_reg) begin
        o_rowbuf_addr <= hcount_reg;
        o_video_char <= i_rowbuf_char;
        o_video_attr <= i_rowbuf_attr;
      end
    end
  end

  // ==========================================================================
  // Register port
  // Writes are taken only while the address bus is not ours.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_reg <= vrf_pkg::CTRL_RESET;
      tbl_lo_reg <= vrf_pkg::REG_RESET;
      tbl_hi_reg <= vrf_pkg::REG_RESET;
      cur_col_reg <= vrf_pkg::REG_RESET;
      cur_row_reg <= vrf_pkg::REG_RESET;
      scr_start_reg <= vrf_pkg::REG_RESET;
      scr_stop_reg <= vrf_pkg::REG_RESET;
      scr_ofs_reg <= vrf_pkg::REG_RESET;
    end else if (i_reg_req.wr && !o_sys_addr_oe) begin
      case (i_reg_req.addr)
        vrf_pkg::REG_CTRL: ctrl_reg <= i_reg_req.wdata;
        vrf_pkg::REG_TBL_LO: tbl_lo_reg <= i_reg_req.wdata;
        vrf_pkg::REG_TBL_HI: tbl_hi_reg <= i_reg_req.wdata;
        vrf_pkg::REG_CUR_COL: cur_col_reg <= i_reg_req.wdata;
        vrf_pkg::REG_CUR_ROW: cur_row_reg <= i_reg_req.wdata;
        vrf_pkg::REG_SCR_START: scr_start_reg <= i_reg_req.wdata;
        vrf_pkg::REG_SCR_STOP: scr_stop_reg <= i_reg_req.wdata;
        vrf_pkg::REG_SCR_OFS: scr_ofs_reg <= i_reg_req.wdata;
        default: begin
        end
      endcase
    end
  end

  // Read data stands in the cycle after the strobe only.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_req.rd && !o_sys_addr_oe) begin
      case (i_reg_req.addr)
        vrf_pkg::REG_CTRL: o_reg_rdata <= ctrl_reg;
        vrf_pkg::REG_TBL_LO: o_reg_rdata <= tbl_lo_reg;
        vrf_pkg::REG_TBL_HI: o_reg_rdata <= tbl_hi_reg;
        vrf_pkg::REG_CUR_COL: o_reg_rdata <= cur_col_reg;
        vrf_pkg::REG_CUR_ROW: o_reg_rdata <= cur_row_reg;
        vrf_pkg::REG_SCR_START: o_reg_rdata <= scr_start_reg;
        vrf_pkg::REG_SCR_STOP: o_reg_rdata <= scr_stop_reg;
        vrf_pkg::REG_SCR_OFS: o_reg_rdata <= scr_ofs_reg;
        vrf_pkg::REG_STATUS: o_reg_rdata <= {4'h0, kind_reg, fetching,
                                             vcount_reg >= 9'(vrf_pkg::V_ACTIVE)};
        vrf_pkg::REG_ROW_NUM: o_reg_rdata <= {row_reg[3:0], line_reg};
        default: o_reg_rdata <= 8'h00;
      endcase
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_granted;
    state_reg == vrf_pkg::FS_REQ && char_en_reg && i_video_bus_grant;
  endsequence
  sequence s_burst_end;
    state_reg == vrf_pkg::FS_BURST && char_en_reg && bcnt_reg == act_len;
  endsequence

  property p_frame_rows;
    row_reg < 5'(vrf_pkg::ROWS) && line_reg < 4'(vrf_pkg::LINES_PER_ROW);
  endproperty
  a_frame_rows: assert property (p_frame_rows) else $error("row or line out of range");

  property p_frame_total;
    line_end && frame_end |=> vcount_reg == 9'h000 && row_reg == 5'h00;
  endproperty
  a_frame_total: assert property (p_frame_total) else $error("frame not 375 lines");

  property p_cell;
    ##1 o_cell_width == ($past(ctrl_reg[vrf_pkg::CTRL_WIDE_BIT]) ? 4'h7 : 4'h9);
  endproperty
  a_cell: assert property (p_cell) else $error("cell width wrong");

  property p_blank;
    o_hsync |-> o_blank;
  endproperty
  a_blank: assert property (p_blank) else $error("sync outside blanking");

  property p_request;
    s_granted |=> state_reg == vrf_pkg::FS_TBL0 && !o_row_boundary_request_n;
  endproperty
  a_request: assert property (p_request) else $error("grant not followed by table read");

  property p_drive;
    o_sys_addr_oe |-> i_address_drive_control && !o_row_boundary_request_n;
  endproperty
  a_drive: assert property (p_drive) else $error("address driven without control");

  property p_release;
    s_burst_end |=> o_row_boundary_request_n && !o_sys_addr_oe;
  endproperty
  a_release: assert property (p_release) else $error("request kept after burst");

  property p_split;
    char_en_reg && state_reg == vrf_pkg::FS_BURST |=>
      o_rowbuf_we && o_rowbuf_char == $past(i_dram_word[7:0]) &&
      o_rowbuf_attr == $past(i_dram_word[15:8]);
  endproperty
  a_split: assert property (p_split) else $error("burst word not split");

  property p_burst_len;
    s_burst_end |-> o_rowbuf_addr == act_len - 8'h02 || act_len == 8'h00;
  endproperty
  a_burst_len: assert property (p_burst_len) else $error("burst length wrong");

  property p_line_zero;
    state_reg == vrf_pkg::FS_BURST |-> line_reg == 4'h0 || hcount_reg == 8'(HT - 1);
  endproperty
  a_line_zero: assert property (p_line_zero) else $error("burst outside line zero");

endmodule

// *** verification/vrf_bus_model.sv ***
// Far side model: arbiter, row table SRAM, DRAM and row buffer SRAM.
`timescale 1ns/1ps
module vrf_bus_model (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Controller side.
  input wire logic i_req_n,
  input wire logic [15:0] i_addr,
  input wire logic i_oe,
  input wire logic [7:0] i_baddr,
  input wire logic i_bwe,
  input wire logic [15:0] i_bwdata,
  input wire logic [15:0] i_key,
  // Answers.
  output logic o_grant,
  output logic [7:0] o_data,
  output logic [15:0] o_word,
  output logic [15:0] o_brdata
);
  logic [15:0] mem [0:255];

  // The arbiter hands over and takes back the bus one clock after the request.
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_grant <= 1'b0;
    end else begin
      o_grant <= ~i_req_n;
    end
  end

  // Table bytes and words follow the address; a released bus shows the inverse.
  // The table is fixed, so software never rewrites it during display.
  always_comb begin
    o_data = i_oe ? {2'h0, i_addr[5:0]} : ~{2'h0, i_addr[5:0]};
    o_word = i_oe ? (i_addr ^ i_key) : ~(i_addr ^ i_key);
  end

  // Row buffer keeps the burst for the later scan lines.
  always_ff @(posedge i_clock) begin
    if (i_bwe) begin
      mem[i_baddr] <= i_bwdata;
    end
  end
  assign o_brdata = mem[i_baddr];
endmodule

// *** verification/vrf_row_fetch_tb.sv ***
// Self-checking bench for the video row fetch controller.
`timescale 1ns/1ps
module vrf_row_fetch_tb;
  localparam logic [15:0] TBL = 16'h0130;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  vrf_pkg::vrf_bus_req_type req = '0;
  logic [7:0] rdata, sys_data, baddr, bchar, battr, v, w;
  logic req_n, grant, oe, bwe, cload, hsync, blank, cursor, gate_n, scanline_serial_data;
  logic [15:0] sys_addr, word, brdata, start, a0;
  logic [15:0] key = '0;
  logic [3:0] cwidth, sh;
  logic prev_req = 1'b1, prev_hs = 1'b0, prev_cur = 1'b0;
  // Wide marks the 132-column burst; hold_hs skips the one line shifted by the mode change.
  logic wide = 1'b0, hold_hs = 1'b0;
  int n_fail = 0, checked = 0, seed = 49;
  int n_fetch = 0, n_word = 0, exp_scan = 0, n_bit = 0, n_cur = 0, period = 0;

  // Clock of 100 ns.
  always #50 clk = ~clk;

  vrf_row_fetch dut (.i_clock(clk), .i_rst_n(rst_n), .i_reg_req(req), .o_reg_rdata(rdata),
    .o_row_boundary_request_n(req_n), .i_video_bus_grant(grant),
    .i_address_drive_control(grant), .o_sys_addr(sys_addr), .o_sys_addr_oe(oe),
    .i_sys_data(sys_data), .i_dram_word(word), .o_rowbuf_addr(baddr), .o_rowbuf_we(bwe),
    .o_rowbuf_char(bchar), .o_rowbuf_attr(battr), .i_rowbuf_char(brdata[7:0]),
    .i_rowbuf_attr(brdata[15:8]), .o_char_load(cload), .o_video_char(), .o_video_attr(),
    .o_cell_width(cwidth), .o_hsync(hsync), .o_vsync(), .o_blank(blank),
    .o_visible_line_time(), .o_cursor(cursor), .o_scanline_gate_n(gate_n),
    .o_scanline_serial_data(scanline_serial_data));

  vrf_bus_model u_bus (.i_clock(clk), .i_rst_n(rst_n), .i_req_n(req_n), .i_addr(sys_addr),
    .i_oe(oe), .i_baddr(baddr), .i_bwe(bwe), .i_bwdata({battr, bchar}), .i_key(key),
    .o_grant(grant), .o_data(sys_data), .o_word(word), .o_brdata(brdata));

  // Compares one value and counts it.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  // Register bus cycles.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) req <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) req <= '0;
    #1 d = rdata;
  endtask

  // Prints the verdict and ends the run.
  task automatic complete_run();
    if (n_fail == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Bench model of line timing, row fetch, scan report and cursor.
  always @(posedge clk) begin
    if (rst_n) begin
      period++;
      if (hsync) check(16'(blank), 16'h1);
      if (oe) check(16'(grant), 16'h1);
      if (hsync && !prev_hs) begin
        if (n_fetch > 0 && !hold_hs) check(16'(period), 16'(vrf_pkg::H_TOTAL * 2));
        period = 0;
        hold_hs = 1'b0;
      end
      if (!req_n && prev_req) begin
        if (n_fetch > 0) check(16'(exp_scan), 16'd13);
        if (n_fetch == 1) check(16'(n_cur), 16'd13);
        n_fetch++;
        n_word = 0;
        exp_scan = 0;
        n_cur = 0;
        a0 = TBL + 16'(2 * n_fetch);
        start = {2'h0, 6'(a0 + 16'h1), 2'h0, a0[5:0]};
      end
      // The last word lands in the same cycle as the request is withdrawn.
      if (bwe) begin
        check({battr, bchar}, (start + 16'(n_word)) ^ key);
        check(16'(baddr), 16'(n_word));
        n_word++;
      end
      if (req_n && !prev_req) begin
        check(16'(n_word), wide ? 16'(vrf_pkg::COLS_WIDE) :
                                  16'(vrf_pkg::COLS_NARROW));
      end
      if (gate_n) n_bit = 0;
      if (cload && !gate_n) begin
        sh = {sh[2:0], scanline_serial_data};
        n_bit++;
        if (n_bit == 4 && n_fetch > 0) begin
          check(16'(sh), 16'(exp_scan));
          exp_scan++;
        end
      end
      if (cursor && !prev_cur) n_cur++;
      prev_req = req_n;
      prev_hs = hsync;
      prev_cur = cursor;
    end
  end

  // Main sequence.
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    key <= 16'($random(seed));
    for (int a = 0; a < 8; a++) begin
      rd(4'(a), v);
      check(16'(v), 16'(vrf_pkg::REG_RESET));
    end
    rd(4'hF, v);
    check(16'(v), 16'h0);
    check(16'(cwidth), 16'(vrf_pkg::CELL_DOTS_NARROW));
    wr(vrf_pkg::REG_TBL_LO, TBL[7:0]);
    wr(vrf_pkg::REG_TBL_HI, TBL[15:8]);
    for (int a = 3; a < 8; a++) begin
      v = 8'($unsigned($random(seed)) % 80);
      if (a == 7) v = v % 8'd13;
      if (a == 4) v = 8'h01;
      if (a == 5) v = 8'h14;
      if (a == 6) v = 8'h18;
      wr(4'(a), v);
      rd(4'(a), w);
      check(16'(w), 16'(v));
    end
    wr(vrf_pkg::REG_CTRL, 8'h02);
    while (n_fetch < 3 || !req_n) @(posedge clk);
    wr(vrf_pkg::REG_CTRL, 8'h03);
    wide = 1'b1;
    hold_hs = 1'b1;
    while (n_fetch < 4 || !req_n) @(posedge clk);
    repeat (4) @(posedge clk);
    check(16'(cwidth), 16'(vrf_pkg::CELL_DOTS_WIDE));
    complete_run();
  end

  // Watchdog well beyond four row fetches.
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    complete_run();
  end
endmodule
